// *** hw/clock_switch_fail_safe_ctrl.v ***
// Notes on behaviour
// - Nine-bit multiplier code gives factor code plus two; resets to fifty.
// - Six-bit trim code is two's-complement, about 0.375 percent per step.
// - Switching and fail-safe monitor work only when switch fuse reads zero.
// - Switching disabled: next-source field ignored, current source follows fuses.
// - Switching disabled: switch request has no effect and reads zero.
// - Next source equal to current source: request cleared, switch aborted.
// - A valid switch start clears PLL-lock status and clock-fail flag.
// - Target enabled; wait for start-up timer and PLL lock as needed.
// - Ten cycles of the new clock pass before the handover.
// - On completion request clears and next source copies into current source.
// - Old source turned off, except low-power RC or kept secondary.
// - Instruction execution never stalls during a switch.
// - Primary submode comes from fuses only, never from software.
// - With fail-safe monitor on, low-power RC runs except in Sleep.
// - On oscillator failure raise a trap and fall back to fast RC.
// - Fallback uses fast RC with PLL when PLL was in use.
// - Next-source changes accepted only while configuration is unlocked.
// - Source codes: fast RC, with PLL, primary, with PLL, secondary, etc.
// - Hardware sets clock-fail flag; software may clear but never set it.
// - Lock bit with second fuse one blocks clock and PLL writes.
`timescale 1ns/1ps
`include "clock_switch_defines.vh"

module clock_switch_fail_safe_ctrl (
  // Clock and reset.
  input  wire        hclk,
  input  wire        hresetn,
  // AHB-Lite slave.
  input  wire        hsel,
  input  wire [7:0]  haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // Configuration fuses.
  input  wire        switch_cfg_fuse_hi,
  input  wire        switch_cfg_fuse_lo,
  input  wire [2:0]  initial_source_fuses,
  input  wire [1:0]  primary_submode_fuses,
  // Oscillator status.
  input  wire        osc_startup_timer,
  input  wire        pll_lock_in,
  input  wire        new_clk_tick,
  input  wire        osc_fail_detect,
  input  wire        wdt_enabled,
  input  wire        sleep_mode,
  // Clock control outputs.
  output reg  [2:0]  sys_clk_sel,
  output reg  [4:0]  osc_enable,
  output reg  [1:0]  primary_submode,
  output reg  [8:0]  pll_mult_code,
  output reg  [9:0]  pll_factor,
  output reg  [5:0]  rc_trim_code,
  output reg         clock_fail_trap,
  output reg         switch_busy
);

  localparam [3:0] S_IDLE   = 4'b0001;
  localparam [3:0] S_WAIT   = 4'b0010;
  localparam [3:0] S_SETTLE = 4'b0100;
  localparam [3:0] S_DONE   = 4'b1000;

  reg  [3:0] state_reg;
  reg  [3:0] state_next;
  reg  [3:0] settle_reg;
  reg  [3:0] settle_next;
  reg  [2:0] cur_src_reg;
  reg  [2:0] cur_src_next;
  reg  [2:0] next_src_reg;
  reg  [2:0] next_src_next;
  reg        req_reg;
  reg        req_next;
  reg        fail_reg;
  reg        fail_next;
  reg        pll_lock_reg;
  reg        pll_lock_next;
  reg        cfg_lock_reg;
  reg        sec_on_reg;
  reg        sw_en_reg;
  reg        straps_done_reg;
  reg        fail_prev_reg;
  reg  [1:0] unlock_reg;
  reg  [1:0] unlock_next;
  reg        trap_next;
  reg  [4:0] en_next;
  reg [31:0] rdata_next;
  reg        wr_pend_reg;
  reg  [7:0] wr_addr_reg;

  wire       addr_phase = hsel & hready & htrans[`HTRANS_ACTIVE];
  wire       wr_now     = wr_pend_reg;
  wire       wr_ctl     = wr_now & (wr_addr_reg == `OFF_OSC_CONTROL);
  wire       wr_key     = wr_now & (wr_addr_reg == `OFF_UNLOCK_KEY);
  wire       cfg_locked = cfg_lock_reg & switch_cfg_fuse_lo;
  wire       ctl_ok     = wr_ctl & (unlock_reg == 2'h2);
  // A failure input already high when the block leaves reset raises no trap,
  // because the previous sample follows it from the first edge on.
  wire       fail_rise  = osc_fail_detect & ~fail_prev_reg;

  // Oscillators a source code needs.
  // source code decode
  function [4:0] need_mask;
    input [2:0] code;
    begin
      need_mask = 5'h00;
      if (code == `SRC_FRC || code == `SRC_FRC_DIV16 || code == `SRC_FRC_DIVN) begin
        need_mask[`EN_FRC] = 1'b1;
      end else if (code == `SRC_FRC_PLL) begin
        need_mask[`EN_FRC] = 1'b1;
        need_mask[`EN_PLL] = 1'b1;
      end else if (code == `SRC_PRI) begin
        need_mask[`EN_PRI] = 1'b1;
      end else if (code == `SRC_PRI_PLL) begin
        need_mask[`EN_PRI] = 1'b1;
        need_mask[`EN_PLL] = 1'b1;
      end else if (code == `SRC_SEC) begin
        need_mask[`EN_SEC] = 1'b1;
      end else begin
        need_mask[`EN_LOW_POWER_RC_OSC] = 1'b1;
      end
    end
  endfunction

  wire [4:0] tgt_mask = need_mask(next_src_reg);
  wire       tgt_ready = (~tgt_mask[`EN_PRI] | osc_startup_timer) &
                         (~tgt_mask[`EN_PLL] | pll_lock_in);

  // Register read mux, sampled in the address phase.
  always @* begin
    rdata_next = 32'h0000_0000;
    if (haddr == `OFF_OSC_CONTROL) begin
      rdata_next[`CTL_CUR_HI:`CTL_CUR_LO]   = cur_src_reg;
      rdata_next[`CTL_NEXT_HI:`CTL_NEXT_LO] = next_src_reg;
      rdata_next[`CTL_LOCK_BIT]             = cfg_lock_reg;
      rdata_next[`CTL_PLL_LOCK_BIT]         = pll_lock_reg;
      rdata_next[`CTL_FAIL_BIT]             = fail_reg;
      rdata_next[`CTL_SEC_ON_BIT]           = sec_on_reg;
      rdata_next[`CTL_REQ_BIT]              = req_reg & sw_en_reg;
    end else if (haddr == `OFF_PLL_FEEDBACK) begin
      rdata_next[`PLL_MULT_HI:0] = pll_mult_code;
    end else if (haddr == `OFF_RC_TUNING) begin
      rdata_next[`RC_TRIM_HI:0] = rc_trim_code;
    end else begin
      // Unmapped offsets and the write-only key register read as zero.
      rdata_next = 32'h0000_0000;
    end
  end

  // Unlock key sequencing.
  always @* begin
    unlock_next = unlock_reg;
    // The first key always restarts the sequence; the second key right after it advances it; any other key value drops it.
    if (wr_key) begin
      if (hwdata[`KEY_HI:0] == `UNLOCK_KEY_A) begin
        unlock_next = 2'h1;
      end else if (unlock_reg == 2'h1 && hwdata[`KEY_HI:0] == `UNLOCK_KEY_B) begin
        unlock_next = 2'h2;
      end else begin
        unlock_next = 2'h0;
      end
    end else if (wr_now) begin
      // any other write consumes the unlock
      unlock_next = 2'h0;
    end
  end

  // Switch sequencer and fail-safe monitor.
  always @* begin
    state_next    = state_reg;
    settle_next   = settle_reg;
    cur_src_next  = cur_src_reg;
    next_src_next = next_src_reg;
    req_next      = req_reg;
    fail_next     = fail_reg;
    pll_lock_next = pll_lock_in;
    trap_next     = 1'b0;
    if (ctl_ok) begin
      if (!cfg_locked && sw_en_reg) begin
        next_src_next = hwdata[`CTL_NEXT_HI:`CTL_NEXT_LO];
      end
      if (hwdata[`CTL_REQ_BIT] && sw_en_reg) begin
        req_next = 1'b1;
      end
      if (!hwdata[`CTL_FAIL_BIT]) begin
        fail_next = 1'b0;
      end
    end
    case (state_reg)
      S_IDLE: begin
        if (req_reg && sw_en_reg) begin
          if (next_src_reg == cur_src_reg) begin
            req_next = 1'b0;
          end else begin
            // The lock status follows the PLL again from the next cycle on.
            // clear lock and fail flag
            pll_lock_next = 1'b0;
            fail_next     = 1'b0;
            state_next    = S_WAIT;
          end
        end
      end
      S_WAIT: begin
        if (tgt_ready) begin
          settle_next = `SETTLE_ZERO;
          state_next  = S_SETTLE;
        end
      end
      S_SETTLE: begin
        if (new_clk_tick) begin
          settle_next = settle_reg + `SETTLE_ONE;
          // The count starts at zero, so the tenth tick comes with the count at nine.
          if (settle_reg == `SETTLE_TICKS - `SETTLE_ONE) begin
            // Completion clears the request even if software sets it in this cycle.
            // handover and completion
            cur_src_next = next_src_reg;
            req_next     = 1'b0;
            state_next   = S_DONE;
          end
        end
      end
      S_DONE: begin
        state_next = S_IDLE;
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
    // The failure path comes after the software clear, so an event and a
    // clear in the same cycle leave the flag set.
    // failure trap and fallback
    if (sw_en_reg && fail_rise) begin
      fail_next  = 1'b1;
      trap_next  = 1'b1;
      req_next   = 1'b0;
      state_next = S_IDLE;
      if (cur_src_reg == `SRC_FRC_PLL || cur_src_reg == `SRC_PRI_PLL) begin
        cur_src_next = `SRC_FRC_PLL;
      end else begin
        cur_src_next = `SRC_FRC;
      end
    end
    // Disabled switching overrides all of the above, so a stray request or
    // failure edge can never move the clock.
    // disabled, current source follows fuses
    if (!sw_en_reg) begin
      cur_src_next = initial_source_fuses;
      req_next     = 1'b0;
      state_next   = S_IDLE;
    end
  end

  // Oscillator enables.
  always @* begin
    en_next = need_mask(cur_src_next);
    // Old and target sources both run while waiting and settling, so the
    // system clock keeps a live source until the handover.
    if (state_next == S_WAIT || state_next == S_SETTLE) begin
      en_next = en_next | tgt_mask;
    end
    if (sec_on_reg) begin
      en_next[`EN_SEC] = 1'b1;
    end
    if ((wdt_enabled || sw_en_reg) && !sleep_mode) begin
      en_next[`EN_LOW_POWER_RC_OSC] = 1'b1;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata          <= 32'h0000_0000;
      hreadyout       <= 1'b1;
      hresp           <= 1'b0;
      wr_pend_reg     <= 1'b0;
      wr_addr_reg     <= 8'h00;
      unlock_reg      <= 2'h0;
      state_reg       <= S_IDLE;
      settle_reg      <= `SETTLE_ZERO;
      cur_src_reg     <= `SRC_FRC;
      next_src_reg    <= `SRC_FRC;
      req_reg         <= 1'b0;
      fail_reg        <= 1'b0;
      pll_lock_reg    <= 1'b0;
      cfg_lock_reg    <= 1'b0;
      sec_on_reg      <= 1'b0;
      sw_en_reg       <= 1'b0;
      straps_done_reg <= 1'b0;
      fail_prev_reg   <= 1'b0;
      sys_clk_sel     <= `SRC_FRC;
      osc_enable      <= `OSC_EN_RESET;
      primary_submode <= 2'h0;
      pll_mult_code   <= `PLL_MULT_RESET;
      pll_factor      <= `PLL_FACTOR_RESET;
      rc_trim_code    <= `RC_TRIM_RESET;
      clock_fail_trap <= 1'b0;
      switch_busy     <= 1'b0;
    end else begin
      // Every transfer completes in its data phase with an OKAY response.
      // zero-wait bus, core never stalled
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      wr_pend_reg <= addr_phase & hwrite;
      if (addr_phase) begin
        wr_addr_reg <= haddr;
      end
      if (addr_phase && !hwrite) begin
        hrdata <= rdata_next;
      end
      unlock_reg    <= unlock_next;
      fail_prev_reg <= osc_fail_detect;
      // The switch and submode fuses are taken once, on the first edge after reset; the mode and
      // the submode then stay fixed until the next reset.
      if (!straps_done_reg) begin
        sw_en_reg       <= ~switch_cfg_fuse_hi;
        primary_submode <= primary_submode_fuses;
        cur_src_reg     <= initial_source_fuses;
        next_src_reg    <= initial_source_fuses;
        sys_clk_sel     <= initial_source_fuses;
        straps_done_reg <= 1'b1;
      end else begin
        state_reg       <= state_next;
        settle_reg      <= settle_next;
        cur_src_reg     <= cur_src_next;
        next_src_reg    <= next_src_next;
        req_reg         <= req_next;
        fail_reg        <= fail_next;
        pll_lock_reg    <= pll_lock_next;
        sys_clk_sel     <= cur_src_next;
        osc_enable      <= en_next;
        clock_fail_trap <= trap_next;
        switch_busy     <= (state_next != S_IDLE);
      end
      // With the lock fuse set, only a reset can clear the lock bit again.
      if (ctl_ok && !cfg_locked) begin
        cfg_lock_reg <= hwdata[`CTL_LOCK_BIT];
      end
      // The secondary enable selects no clock, so the lock leaves it open.
      if (ctl_ok) begin
        sec_on_reg <= hwdata[`CTL_SEC_ON_BIT];
      end
      if (wr_now && wr_addr_reg == `OFF_PLL_FEEDBACK && !cfg_locked) begin
        pll_mult_code <= hwdata[`PLL_MULT_HI:0];
        pll_factor    <= {1'b0, hwdata[`PLL_MULT_HI:0]} + `PLL_MULT_OFFSET;
      end
      // The trim value is not guarded by the lock, as it selects no source.
      // signed trim steps
      if (wr_now && wr_addr_reg == `OFF_RC_TUNING) begin
        rc_trim_code <= hwdata[`RC_TRIM_HI:0];
      end
    end
  end

endmodule // clock_switch_fail_safe_ctrl

// *** hw/clock_switch_defines.vh ***
`ifndef CLOCK_SWITCH_DEFINES_VH
`define CLOCK_SWITCH_DEFINES_VH

// Register byte offsets.
`define OFF_OSC_CONTROL   8'h00
`define OFF_PLL_FEEDBACK  8'h04
`define OFF_RC_TUNING     8'h08
`define OFF_UNLOCK_KEY    8'h0c

// Unlock key values, two writes in a row to the key register.
`define UNLOCK_KEY_A      16'h5a5a
`define UNLOCK_KEY_B      16'ha5a5

// Control register field positions.
`define CTL_CUR_HI        14
`define CTL_CUR_LO        12
`define CTL_NEXT_HI       10
`define CTL_NEXT_LO       8
`define CTL_LOCK_BIT      7
`define CTL_PLL_LOCK_BIT  5
`define CTL_FAIL_BIT      3
`define CTL_SEC_ON_BIT    1
`define CTL_REQ_BIT       0

// Reset values.
`define PLL_MULT_RESET    9'h030
`define RC_TRIM_RESET     6'h00
`define PLL_MULT_OFFSET   10'h002
`define PLL_FACTOR_RESET  10'h032
`define OSC_EN_RESET      5'h01

// Top bits of the data fields.
`define PLL_MULT_HI       8
`define RC_TRIM_HI        5
`define KEY_HI            15

// Source codes.
`define SRC_FRC           3'h0
`define SRC_FRC_PLL       3'h1
`define SRC_PRI           3'h2
`define SRC_PRI_PLL       3'h3
`define SRC_SEC           3'h4
`define SRC_LOW_POWER_RC_OSC          3'h5
`define SRC_FRC_DIV16     3'h6
`define SRC_FRC_DIVN      3'h7

// Oscillator enable vector positions.
`define EN_FRC            0
`define EN_PRI            1
`define EN_SEC            2
`define EN_LOW_POWER_RC_OSC           3
`define EN_PLL            4

// Settle wait in cycles of the new source.
`define SETTLE_TICKS      4'ha
`define SETTLE_ZERO       4'h0
`define SETTLE_ONE        4'h1

// AHB transfer type bit for NONSEQ or SEQ.
`define HTRANS_ACTIVE     1

`endif

// *** test/clock_switch_checker_properties.sv ***
`timescale 1ns/1ps
module clock_switch_checker (
  // Clock and reset.
  input wire       hclk,
  input wire       hresetn,
  // Fuses and oscillator status.
  input wire       switch_cfg_fuse_hi,
  input wire [2:0] initial_source_fuses,
  input wire       osc_startup_timer,
  input wire       pll_lock_in,
  input wire       new_clk_tick,
  input wire       osc_fail_detect,
  input wire       sleep_mode,
  // Clock control outputs.
  input wire [2:0] sys_clk_sel,
  input wire [4:0] osc_enable,
  input wire [1:0] primary_submode,
  input wire [8:0] pll_mult_code,
  input wire [9:0] pll_factor,
  input wire       clock_fail_trap,
  input wire       switch_busy
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  reg  [1:0] age_reg;
  reg  [3:0] tick_reg;
  wire       up = age_reg == 2'h3;
  wire       on = !switch_cfg_fuse_hi;
  // Counts edges since reset and ticks seen while the target is ready.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      age_reg <= 2'h0;
      tick_reg <= 4'h0;
    end else begin
      if (!up)
        age_reg <= age_reg + 2'h1;
      if (!switch_busy)
        tick_reg <= 4'h0;
      else if (new_clk_tick && osc_startup_timer && pll_lock_in)
        tick_reg <= tick_reg + 4'h1;
    end
  end
  AST_FACTOR: assert property (pll_factor == {1'b0, pll_mult_code} + 10'h002)
    else $error("pll factor is not code plus two");
  AST_NO_SWITCH: assert property (up && !on |-> !switch_busy && !clock_fail_trap)
    else $error("switch activity while switching is off");
  AST_TRACK: assert property (up && !on |=> sys_clk_sel == $past(initial_source_fuses))
    else $error("select does not follow fuses");
  AST_TRAP_PULSE: assert property (clock_fail_trap |=> !clock_fail_trap)
    else $error("trap longer than one cycle");
  AST_TRAP: assert property (up && on && $rose(osc_fail_detect) |=> clock_fail_trap)
    else $error("no trap after failure");
  AST_FALLBACK: assert property (up && on && $rose(osc_fail_detect) |=>
    sys_clk_sel == (($past(sys_clk_sel) == 3'h1 || $past(sys_clk_sel) == 3'h3) ? 3'h1 : 3'h0))
    else $error("wrong fallback source");
  AST_SETTLE: assert property (up && on && $changed(sys_clk_sel) && !clock_fail_trap |->
    tick_reg inside {4'ha, 4'hb} && $past(new_clk_tick))
    else $error("handover not after ten ticks");
  AST_SUBMODE: assert property (up |-> $stable(primary_submode))
    else $error("primary submode changed");
  AST_LOW_POWER_RC_OSC: assert property (up && on && !sleep_mode && !$past(sleep_mode) |-> osc_enable[3])
    else $error("low power oscillator off");
  C_START: cover property (on && $rose(switch_busy));
  C_DONE: cover property (on && $fell(switch_busy));
  C_TRAP: cover property (clock_fail_trap);
endmodule // clock_switch_checker

// *** test/clock_switch_fail_safe_ctrl_tb.sv ***
`timescale 1ns/1ps
`include "clock_switch_defines.vh"
module clock_switch_fail_safe_ctrl_tb;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] hwdata = 32'h0, hrdata, r, d;
  logic        hreadyout, hresp, trap, busy;
  logic        fuse_hi = 1'b1, fuse_lo = 1'b0, st_ok = 1'b1, lk_ok = 1'b1;
  logic        tick = 1'b0, fail = 1'b0, wdt = 1'b0, slp = 1'b0;
  logic [2:0]  init_src = 3'h0, sel;
  logic [1:0]  sub_fuse = 2'h1, sub;
  logic [4:0]  en;
  logic [8:0]  mult;
  logic [9:0]  fac;
  logic [5:0]  trim;
  wire         hready;
  int          n_fail = 0, compares = 0;
  assign hready = hreadyout;
  always #5 hclk = ~hclk;
  always @(posedge hclk) tick <= 1'($urandom % 2);
  clock_switch_fail_safe_ctrl dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .switch_cfg_fuse_hi(fuse_hi),
    .switch_cfg_fuse_lo(fuse_lo), .initial_source_fuses(init_src),
    .primary_submode_fuses(sub_fuse), .osc_startup_timer(st_ok), .pll_lock_in(lk_ok),
    .new_clk_tick(tick), .osc_fail_detect(fail), .wdt_enabled(wdt), .sleep_mode(slp),
    .sys_clk_sel(sel), .osc_enable(en), .primary_submode(sub), .pll_mult_code(mult),
    .pll_factor(fac), .rc_trim_code(trim), .clock_fail_trap(trap), .switch_busy(busy));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] v);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= v;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
    chk("hresp", 32'h0, 32'(hresp));
  endtask
  task automatic ctl(input logic [31:0] v);
    xfer(1'b1, `OFF_UNLOCK_KEY, {16'h0, `UNLOCK_KEY_A});
    xfer(1'b1, `OFF_UNLOCK_KEY, {16'h0, `UNLOCK_KEY_B});
    xfer(1'b1, `OFF_OSC_CONTROL, v);
  endtask
  task automatic rst(input logic h, input logic [2:0] s);
    hresetn <= 1'b0;
    fuse_hi <= h;
    init_src <= s;
    sub_fuse <= 2'h1;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
  endtask
  function automatic int osc(input logic [2:0] c);
    return (c == 3'h2 || c == 3'h3) ? `EN_PRI : (c == 3'h4) ? `EN_SEC :
           (c == 3'h5) ? `EN_LOW_POWER_RC_OSC : `EN_FRC;
  endfunction
  task automatic go(input logic [2:0] t);
    logic [2:0] old;
    old = sel;
    // Fail bit written as one, so only the switch start may clear the flag.
    ctl({21'h0, t, 8'h08});
    ctl({21'h0, t, 8'h09});
    repeat (200) if (sel !== t) @(posedge hclk);
    repeat (3) @(posedge hclk);
    xfer(1'b0, `OFF_OSC_CONTROL, 32'h0);
    chk("select", 32'(t), 32'(sel));
    chk("current field", 32'(t), 32'(r[14:12]));
    chk("request", 32'h0, 32'(r[0]));
    chk("old osc", 32'(osc(old) == osc(t) || osc(old) == `EN_LOW_POWER_RC_OSC), 32'(en[osc(old)]));
    chk("new osc", 32'h1, 32'(en[osc(t)]));
    chk("pll osc", 32'(t == 3'h1 || t == 3'h3), 32'(en[`EN_PLL]));
  endtask
  task automatic report_and_stop();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #400000;
    n_fail++;
    report_and_stop();
  end
  initial begin
    void'($urandom(40));
    rst(1'b1, `SRC_PRI);
    chk("select", 32'(`SRC_PRI), 32'(sel));
    chk("submode", 32'h1, 32'(sub));
    xfer(1'b0, `OFF_PLL_FEEDBACK, 32'h0);
    chk("pll reset", 32'h30, r);
    chk("factor reset", 32'd50, 32'(fac));
    xfer(1'b0, `OFF_RC_TUNING, 32'h0);
    chk("trim reset", 32'h0, r);
    chk("low_power_rc_osc off", 32'h0, 32'(en[`EN_LOW_POWER_RC_OSC]));
    wdt <= 1'b1;
    repeat (2) @(posedge hclk);
    chk("low_power_rc_osc wdt", 32'h1, 32'(en[`EN_LOW_POWER_RC_OSC]));
    wdt <= 1'b0;
    ctl({21'h0, `SRC_FRC, 8'h01});
    repeat (20) @(posedge hclk);
    xfer(1'b0, `OFF_OSC_CONTROL, 32'h0);
    chk("request", 32'h0, 32'(r[0]));
    chk("current field", 32'(`SRC_PRI), 32'(r[14:12]));
    init_src <= `SRC_SEC;
    repeat (2) @(posedge hclk);
    chk("select", 32'(`SRC_SEC), 32'(sel));
    for (int i = 0; i < 4; i++) begin
      d = $urandom;
      d[8:0] = (i == 0) ? 9'h000 : (i == 1) ? 9'h1ff : d[8:0];
      xfer(1'b1, `OFF_PLL_FEEDBACK, d);
      xfer(1'b0, `OFF_PLL_FEEDBACK, 32'h0);
      chk("pll code", {23'h0, d[8:0]}, r);
      chk("pll out", 32'(d[8:0]), 32'(mult));
      chk("factor", 32'(d[8:0]) + 32'h2, 32'(fac));
      d = $urandom;
      d[5:0] = (i == 0) ? 6'h1f : (i == 1) ? 6'h20 : d[5:0];
      xfer(1'b1, `OFF_RC_TUNING, d);
      xfer(1'b0, `OFF_RC_TUNING, 32'h0);
      chk("trim code", {26'h0, d[5:0]}, r);
      chk("trim out", 32'(d[5:0]), 32'(trim));
    end
    xfer(1'b1, 8'h10, $urandom);
    xfer(1'b0, 8'h10, 32'h0);
    chk("unmapped", 32'h0, r);
    $display("test done: registers with switching off");
    rst(1'b0, `SRC_FRC);
    sub_fuse <= 2'h2;
    xfer(1'b1, `OFF_OSC_CONTROL, {21'h0, `SRC_PRI, 8'h01});
    repeat (30) @(posedge hclk);
    chk("submode", 32'h1, 32'(sub));
    chk("no unlock", 32'(`SRC_FRC), 32'(sel));
    slp <= 1'b1;
    repeat (2) @(posedge hclk);
    chk("low_power_rc_osc sleep", 32'h0, 32'(en[`EN_LOW_POWER_RC_OSC]));
    slp <= 1'b0;
    repeat (2) @(posedge hclk);
    chk("low_power_rc_osc monitor", 32'h1, 32'(en[`EN_LOW_POWER_RC_OSC]));
    for (int t = 0; t < 8; t++) begin
      if (t == 3) begin
        st_ok <= 1'b0;
        lk_ok <= 1'b0;
        fork
          begin
            repeat (40) @(posedge hclk);
            chk("wait lock", 32'h0, 32'(sel === 3'h3));
            st_ok <= 1'b1;
            lk_ok <= 1'b1;
          end
        join_none
      end
      go(3'(t));
    end
    $display("test done: switch sequence");
    fail <= 1'b1;
    repeat (3) @(posedge hclk);
    fail <= 1'b0;
    chk("fallback", 32'(`SRC_FRC), 32'(sel));
    xfer(1'b0, `OFF_OSC_CONTROL, 32'h0);
    chk("fail flag", 32'h1, 32'(r[3]));
    for (int i = 0; i < 3; i++) begin
      ctl((i == 1) ? 32'h0 : 32'h8);
      xfer(1'b0, `OFF_OSC_CONTROL, 32'h0);
      chk("fail flag", 32'(i == 0), 32'(r[3]));
    end
    go(`SRC_PRI_PLL);
    fail <= 1'b1;
    repeat (3) @(posedge hclk);
    fail <= 1'b0;
    chk("fallback", 32'(`SRC_FRC_PLL), 32'(sel));
    xfer(1'b0, `OFF_OSC_CONTROL, 32'h0);
    chk("fail flag", 32'h1, 32'(r[3]));
    go(`SRC_FRC);
    chk("flag cleared", 32'h0, 32'(r[3]));
    $display("test done: fail safe");
    fuse_lo <= 1'b1;
    ctl(32'h80);
    ctl({21'h0, `SRC_PRI, 8'h01});
    repeat (30) @(posedge hclk);
    chk("locked select", 32'(`SRC_FRC), 32'(sel));
    xfer(1'b1, `OFF_PLL_FEEDBACK, 32'h5);
    xfer(1'b0, `OFF_PLL_FEEDBACK, 32'h0);
    chk("locked pll", 32'(`PLL_MULT_RESET), r);
    chk("locked out", 32'(`PLL_MULT_RESET), 32'(mult));
    fuse_lo <= 1'b0;
    xfer(1'b1, `OFF_PLL_FEEDBACK, 32'h5);
    xfer(1'b0, `OFF_PLL_FEEDBACK, 32'h0);
    chk("open pll", 32'h5, r);
    $display("test done: lock");
    report_and_stop();
  end
endmodule // clock_switch_fail_safe_ctrl_tb
bind clock_switch_fail_safe_ctrl clock_switch_checker chk_u (
  .hclk(hclk), .hresetn(hresetn), .switch_cfg_fuse_hi(switch_cfg_fuse_hi),
  .initial_source_fuses(initial_source_fuses), .osc_startup_timer(osc_startup_timer),
  .pll_lock_in(pll_lock_in), .new_clk_tick(new_clk_tick), .osc_fail_detect(osc_fail_detect),
  .sleep_mode(sleep_mode), .sys_clk_sel(sys_clk_sel), .osc_enable(osc_enable),
  .primary_submode(primary_submode), .pll_mult_code(pll_mult_code), .pll_factor(pll_factor),
  .clock_fail_trap(clock_fail_trap), .switch_busy(switch_busy));
